// ==== rtl/fsb_pkg.sv ====
package fsb_pkg;

	// clock rate and the two protected-target polling windows
	localparam int CLK_KHZ = 40000;
	localparam int PROT_PROG_NS = 1000;
	localparam int PROT_ERASE_US = 100;
	localparam int PROT_PROG_CYC = (PROT_PROG_NS * CLK_KHZ) / 1000000;
	localparam int PROT_ERASE_CYC = (PROT_ERASE_US * CLK_KHZ) / 1000;
	localparam int CNT_W = 12;

	// command cycle addresses (low 11 bits) and data codes
	localparam logic [10:0] ADDR_UNL1 = 11'h555;
	localparam logic [10:0] ADDR_UNL2 = 11'h2AA;
	localparam logic [7:0] D_UNL1 = 8'hAA;
	localparam logic [7:0] D_UNL2 = 8'h55;
	localparam logic [7:0] D_PROG = 8'hA0;
	localparam logic [7:0] D_ERASE = 8'h80;
	localparam logic [7:0] D_CHIP = 8'h10;
	localparam logic [7:0] D_SECT = 8'h30;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam logic [7:0] D_SUSP = 8'hB0;
	localparam logic [7:0] D_BYP = 8'h20;
	localparam logic [7:0] D_BYP_RST1 = 8'h90;
	localparam logic [7:0] D_BYP_RST2 = 8'h00;
	localparam logic [7:0] D_RESET = 8'hF0;

	// host pins as one bundle; reset value is the idle level
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic address_valid_n;
		logic bus_clk;
		logic accelerate_pin;
	} fsb_pins_s;
	localparam int PIN_N = 6;
	localparam logic [PIN_N-1:0] PIN_RST = 6'h3C;

	typedef enum logic [1:0] {
		FSB_K_PROG,
		FSB_K_SECT,
		FSB_K_CHIP
	} fsb_kind_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROG,
		ST_PSUSP,
		ST_ERASE,
		ST_ESUSP,
		ST_EPROG,
		ST_PROT,
		ST_FAIL
	} fsb_state_e;

	typedef enum logic [3:0] {
		CY_0,
		CY_1,
		CY_2,
		CY_3,
		CY_4,
		CY_5,
		CY_DATA,
		CY_BCHIP,
		CY_BRST
	} fsb_cyc_e;

endpackage

// ==== rtl/fsb_sequencer.sv ====
`timescale 1ns/10ps
// Contract
// - suspend command halts program, status shows suspend
// - suspended: other sectors read array data
// - secure region blocks erase, resume, bypass, accel; code blocks sector erase, program resume, bypass and accel, not chip erase or erase resume
// - resume continues program; repeats ignored
// - high voltage on accelerate pin enters bypass
// - write-protect pin sectors stay protected
// - accel bypasses protection unless lock bit set
// - dropping high voltage restores normal commands
// - bypass program or chip erase: two cycles
// - bypass accepts only read, program, chip erase, reset
// - two-cycle bypass reset returns to read
// - other bank reads array during operation
// - no concurrent reads in query or password
// - poll bit complements programmed bit until done
// - protected program polls 1 us, no program
// - erase poll bit zero, one when done
// - poll bit may lead other bits
// - toggle bit flips per busy-bank read
// - read cycle defined by enables or strobe
// - all-protected erase toggles 100 us
// - toggle stops in erase suspend, runs programming
// - timing limit flag marks failed operation
// - second toggle flips on erase-selected reads
module fsb_sequencer
	import fsb_pkg::*;
#(
	parameter int AW = 19,
	parameter int DW = 32,
	parameter int SECT_LSB = 14
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire fsb_pins_s pins,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] din,
	input wire logic sync_mode,
	input wire logic secure_en,
	input wire logic query_information_mode,
	input wire logic password_op,
	input wire logic wp_guarded,
	input wire logic sector_lock_hit,
	input wire logic per_sector_lock_bit,
	input wire logic [DW-1:0] arr_rdata,
	output logic [AW-1:0] arr_addr,
	output logic [DW-1:0] dout,
	output logic ready_busy_n_o,
	output logic ready_busy_n_oe,
	output logic eng_start,
	output logic eng_run,
	output fsb_kind_e eng_kind,
	output logic [AW-1:0] eng_addr,
	output logic [DW-1:0] eng_data,
	input wire logic eng_done,
	input wire logic eng_limit,
	output logic timing_limit_flag,
	output logic bypass_active
);

	logic rs1_r, rst_n_r;
	logic [PIN_N-1:0] pin_v, p1_r, p2_r, p3_r, pst_r, pprev_r;
	fsb_pins_s ps, pp;
	logic [AW-1:0] a1_r, a2_r, op_a_r, er_a_r;
	logic [DW-1:0] d1_r, d2_r, op_d_r, dout_r;
	fsb_state_e st_r;
	fsb_cyc_e cyc_r, cyc_nxt;
	fsb_kind_e kind_r, er_kind_r, go_kind;
	logic op_bank_r, op_byp_r, byp_r, prot_ret_r, fail_r, tog1_r, tog2_r;
	logic [CNT_W-1:0] cnt_r;
	logic we_ev, rd_ev, rd_async, rd_sync, acc_mode, bypass, prot, go;
	logic byp_set, byp_clr, eresume, busy_st, in_sel, show_stat;
	logic unl1, unl2;
	logic [7:0] wd, status;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_r <= 1'h0;
			rst_n_r <= 1'h0;
		end else begin
			rs1_r <= 1'h1;
			rst_n_r <= rs1_r;
		end
	end

	// a pin level is taken only once the two late stages agree
	assign pin_v = pins;
	generate
		for (genvar i = 0; i < PIN_N; i++) begin : g_pin
			always_ff @(posedge mclk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					p1_r[i] <= PIN_RST[i];
					p2_r[i] <= PIN_RST[i];
					p3_r[i] <= PIN_RST[i];
					pst_r[i] <= PIN_RST[i];
					pprev_r[i] <= PIN_RST[i];
				end else begin
					p1_r[i] <= pin_v[i];
					p2_r[i] <= p1_r[i];
					p3_r[i] <= p2_r[i];
					if (p2_r[i] == p3_r[i]) begin
						pst_r[i] <= p3_r[i];
					end
					pprev_r[i] <= pst_r[i];
				end
			end
		end
	endgenerate
	assign ps = pst_r;
	assign pp = pprev_r;

	// address and data are stable around the strobes that use them
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			a1_r <= '0;
			a2_r <= '0;
			d1_r <= '0;
			d2_r <= '0;
		end else begin
			a1_r <= addr;
			a2_r <= a1_r;
			d1_r <= din;
			d2_r <= d1_r;
		end
	end

	assign we_ev = ps.we_n & ~pp.we_n & ~ps.ce_n;
	assign rd_async = ~ps.ce_n & ~ps.oe_n & (pp.oe_n | pp.ce_n);
	assign rd_sync = ~ps.ce_n & ((ps.address_valid_n & ~pp.address_valid_n)
		| (ps.bus_clk & ~pp.bus_clk & ~ps.address_valid_n));
	assign rd_ev = sync_mode ? rd_sync : rd_async;

	assign acc_mode = ps.accelerate_pin & ~secure_en;
	assign bypass = byp_r | acc_mode;
	assign prot = wp_guarded
		| (sector_lock_hit & (~acc_mode | per_sector_lock_bit));

	assign wd = d2_r[7:0];
	assign unl1 = a2_r[10:0] == ADDR_UNL1;
	assign unl2 = a2_r[10:0] == ADDR_UNL2;

	// command cycles are decoded only while the array is free to accept
	always_comb begin
		cyc_nxt = cyc_r;
		go = 1'h0;
		go_kind = FSB_K_PROG;
		byp_set = 1'h0;
		byp_clr = 1'h0;
		eresume = 1'h0;
		if (we_ev && (st_r == ST_IDLE || st_r == ST_ESUSP)) begin
			cyc_nxt = CY_0;
			unique case (cyc_r)
				CY_0: begin
					if (bypass) begin
						if (wd == D_PROG) begin
							cyc_nxt = CY_DATA;
						end else if (wd == D_ERASE && st_r == ST_IDLE) begin
							cyc_nxt = CY_BCHIP;
						end else if (wd == D_BYP_RST1) begin
							cyc_nxt = CY_BRST;
						end
					end else if (st_r == ST_ESUSP && wd == D_RESUME) begin
						eresume = 1'h1;
					end else if (wd == D_UNL1 && unl1) begin
						cyc_nxt = CY_1;
					end
				end
				CY_1: begin
					if (wd == D_UNL2 && unl2) begin
						cyc_nxt = CY_2;
					end
				end
				CY_2: begin
					if (unl1 && wd == D_PROG) begin
						cyc_nxt = CY_DATA;
					end else if (unl1 && wd == D_ERASE && st_r == ST_IDLE) begin
						cyc_nxt = CY_3;
					end else if (unl1 && wd == D_BYP && st_r == ST_IDLE) begin
						byp_set = ~secure_en;
					end
				end
				CY_3: begin
					if (wd == D_UNL1 && unl1) begin
						cyc_nxt = CY_4;
					end
				end
				CY_4: begin
					if (wd == D_UNL2 && unl2) begin
						cyc_nxt = CY_5;
					end
				end
				CY_5: begin
					if (wd == D_CHIP) begin
						go = 1'h1;
						go_kind = FSB_K_CHIP;
					end else if (wd == D_SECT && !secure_en) begin
						go = 1'h1;
						go_kind = FSB_K_SECT;
					end
				end
				CY_DATA: begin
					go = 1'h1;
				end
				CY_BCHIP: begin
					if (wd == D_CHIP) begin
						go = 1'h1;
						go_kind = FSB_K_CHIP;
					end
				end
				CY_BRST: begin
					byp_clr = wd == D_BYP_RST2;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cyc_r <= CY_0;
			byp_r <= 1'h0;
		end else begin
			cyc_r <= cyc_nxt;
			if (byp_set) begin
				byp_r <= 1'h1;
			end else if (byp_clr) begin
				byp_r <= 1'h0;
			end
		end
	end

	// operation state; engine result outranks any host write
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= ST_IDLE;
			kind_r <= FSB_K_PROG;
			er_kind_r <= FSB_K_SECT;
			op_a_r <= '0;
			er_a_r <= '0;
			op_d_r <= '0;
			op_bank_r <= 1'h0;
			op_byp_r <= 1'h0;
			prot_ret_r <= 1'h0;
			fail_r <= 1'h0;
			cnt_r <= '0;
			eng_start <= 1'h0;
		end else begin
			eng_start <= 1'h0;
			unique case (st_r)
				ST_IDLE, ST_ESUSP: begin
					if (go) begin
						op_a_r <= a2_r;
						op_d_r <= d2_r;
						kind_r <= go_kind;
						op_bank_r <= a2_r[AW-1];
						op_byp_r <= bypass;
						if (go_kind != FSB_K_PROG) begin
							er_a_r <= a2_r;
							er_kind_r <= go_kind;
						end
						if (go_kind != FSB_K_CHIP && prot) begin
							st_r <= ST_PROT;
							prot_ret_r <= st_r == ST_ESUSP;
							cnt_r <= go_kind == FSB_K_PROG
								? CNT_W'(PROT_PROG_CYC - 1)
								: CNT_W'(PROT_ERASE_CYC - 1);
						end else begin
							eng_start <= 1'h1;
							if (st_r == ST_ESUSP) begin
								st_r <= ST_EPROG;
							end else if (go_kind == FSB_K_PROG) begin
								st_r <= ST_PROG;
							end else begin
								st_r <= ST_ERASE;
							end
						end
					end else if (eresume) begin
						st_r <= ST_ERASE;
						kind_r <= er_kind_r;
						op_a_r <= er_a_r;
						op_bank_r <= er_a_r[AW-1];
					end
				end
				ST_PROG, ST_ERASE, ST_EPROG: begin
					if (eng_limit) begin
						st_r <= ST_FAIL;
						fail_r <= 1'h1;
					end else if (eng_done) begin
						st_r <= st_r == ST_EPROG ? ST_ESUSP : ST_IDLE;
					end else if (we_ev && wd == D_SUSP && !op_byp_r) begin
						// bypass operations cannot be suspended
						if (st_r == ST_PROG) begin
							st_r <= ST_PSUSP;
						end else if (st_r == ST_ERASE
							&& kind_r == FSB_K_SECT) begin
							st_r <= ST_ESUSP;
						end
					end
				end
				ST_PSUSP: begin
					if (we_ev && wd == D_RESUME && !secure_en) begin
						st_r <= ST_PROG;
					end
				end
				ST_PROT: begin
					if (cnt_r == '0) begin
						st_r <= prot_ret_r ? ST_ESUSP : ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'h1;
					end
				end
				ST_FAIL: begin
					if (we_ev && wd == D_RESET) begin
						st_r <= ST_IDLE;
						fail_r <= 1'h0;
					end
				end
			endcase
		end
	end

	assign busy_st = st_r == ST_PROG || st_r == ST_ERASE
		|| st_r == ST_EPROG || st_r == ST_PROT || st_r == ST_FAIL;
	assign in_sel = er_kind_r == FSB_K_CHIP
		|| a2_r[AW-1:SECT_LSB] == er_a_r[AW-1:SECT_LSB];

	// status replaces array data where the operation lives, and in any bank while busy in query or password mode
	always_comb begin
		show_stat = 1'h0;
		if (busy_st) begin
			show_stat = a2_r[AW-1] == op_bank_r
				|| query_information_mode || password_op;
		end
		if (st_r == ST_PSUSP) begin
			show_stat = a2_r[AW-1:SECT_LSB] == op_a_r[AW-1:SECT_LSB];
		end
		if ((st_r == ST_ERASE || st_r == ST_ESUSP || st_r == ST_EPROG)
			&& in_sel) begin
			show_stat = 1'h1;
		end
	end

	always_comb begin
		status = 8'h00;
		if (st_r == ST_ESUSP) begin
			status[7] = 1'h1;
		end else if (kind_r == FSB_K_PROG) begin
			status[7] = ~op_d_r[7];
		end else begin
			status[7] = 1'h0;
		end
		status[6] = tog1_r;
		status[5] = fail_r;
		status[2] = tog2_r;
	end

	// first toggle is frozen in both suspend states; the second still flips in erase suspend
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tog1_r <= 1'h0;
			tog2_r <= 1'h0;
		end else if (rd_ev) begin
			if (show_stat && busy_st) begin
				tog1_r <= ~tog1_r;
			end
			if (in_sel && (st_r == ST_ERASE || st_r == ST_ESUSP)) begin
				tog2_r <= ~tog2_r;
			end
		end
	end

	// whole word switches at once, so no lead of the poll bit
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dout_r <= '0;
		end else if (show_stat) begin
			dout_r <= DW'(status);
		end else begin
			dout_r <= arr_rdata;
		end
	end

	assign dout = dout_r;
	assign arr_addr = a2_r;
	assign ready_busy_n_o = 1'h0;
	assign ready_busy_n_oe = busy_st;
	assign eng_run = st_r == ST_PROG || st_r == ST_ERASE
		|| st_r == ST_EPROG;
	assign eng_kind = kind_r;
	assign eng_addr = op_a_r;
	assign eng_data = op_d_r;
	assign timing_limit_flag = fail_r;
	assign bypass_active = bypass;

endmodule

// ==== verification/fsb_chk.sv ====
`timescale 1ns/10ps
module fsb_chk
	import fsb_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire fsb_pins_s pins,
	input wire logic secure_en,
	input wire logic query_information_mode,
	input wire logic password_op,
	input wire logic [18:0] arr_addr,
	input wire logic [31:0] arr_rdata,
	input wire logic [31:0] dout,
	input wire logic ready_busy_n_oe,
	input wire logic eng_start,
	input wire logic eng_run,
	input wire fsb_kind_e eng_kind,
	input wire logic [18:0] eng_addr,
	input wire logic eng_done,
	input wire logic eng_limit,
	input wire logic timing_limit_flag,
	input wire logic bypass_active
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	AST_START_PULSE: assert property (eng_start |=> !eng_start)
		else $error("start pulse longer than one cycle");
	AST_START_BUSY: assert property (eng_start |-> eng_run && ready_busy_n_oe)
		else $error("started operation not busy");
	AST_LIMIT_SET: assert property (eng_limit && eng_run |=> timing_limit_flag)
		else $error("limit flag not raised");
	AST_LIMIT_CAUSE: assert property ($rose(timing_limit_flag) |-> $past(eng_limit))
		else $error("limit flag raised without cause");
	AST_LIMIT_STOP: assert property (eng_limit && eng_run |=> !eng_run)
		else $error("engine runs after limit");
	AST_DONE_READY: assert property (eng_done && eng_run |=> !ready_busy_n_oe)
		else $error("busy after completion");
	AST_ACCEL: assert property ((pins.accelerate_pin && !secure_en)[*8] |-> bypass_active)
		else $error("accelerate pin did not enter bypass");
	AST_OTHER_BANK: assert property (arr_addr[18] != eng_addr[18]
		&& eng_kind != FSB_K_CHIP && !query_information_mode && !password_op
		|=> dout == $past(arr_rdata))
		else $error("other bank read not array data");
endmodule
bind fsb_sequencer fsb_chk u_chk (.mclk, .arst_n, .pins, .secure_en,
	.query_information_mode, .password_op, .arr_addr, .arr_rdata, .dout,
	.ready_busy_n_oe, .eng_start, .eng_run, .eng_kind, .eng_addr, .eng_done,
	.eng_limit, .timing_limit_flag, .bypass_active);

// ==== verification/fsb_host.sv ====
`timescale 1ns/10ps
module fsb_host
	import fsb_pkg::*;
(
	input wire logic mclk,
	input wire logic [31:0] dout,
	output fsb_pins_s pins,
	output logic [18:0] addr,
	output logic [31:0] din
);
	initial begin
		pins = PIN_RST;
		addr = 19'h0;
		din = 32'h0;
	end
	// released lines show the inverse so a stale value never looks valid
	task wr(input logic [18:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		din <= d;
		pins.ce_n <= 1'h0;
		pins.we_n <= 1'h0;
		repeat (4) @(posedge mclk);
		pins.we_n <= 1'h1;
		repeat (4) @(posedge mclk);
		pins.ce_n <= 1'h1;
		addr <= ~a;
		din <= ~d;
		// the filter delays the strobe, so wait until the write is taken
		repeat (4) @(posedge mclk);
	endtask
	task rd(input logic [18:0] a, output logic [31:0] q);
		@(posedge mclk);
		addr <= a;
		pins.ce_n <= 1'h0;
		repeat (4) @(posedge mclk);
		pins.oe_n <= 1'h0;
		repeat (8) @(posedge mclk);
		q = dout;
		pins.oe_n <= 1'h1;
		repeat (4) @(posedge mclk);
		pins.ce_n <= 1'h1;
		addr <= ~a;
	endtask
	task acc(input logic v);
		@(posedge mclk);
		pins.accelerate_pin <= v;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ==== verification/flash_suspend_bypass_status_tb_top.sv ====
`timescale 1ns/10ps
module flash_suspend_bypass_status_tb_top
	import fsb_pkg::*;
;
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic secure_en = 1'h0;
	logic wp_guarded = 1'h0;
	logic eng_done = 1'h0;
	logic eng_limit = 1'h0;
	logic query_information_mode = 1'h0;
	logic sector_lock_hit = 1'h0;
	logic per_sector_lock_bit = 1'h0;
	logic ready_busy_n_o;
	logic ready_busy_n_oe, eng_start, eng_run, timing_limit_flag, bypass_active;
	fsb_pins_s pins;
	fsb_kind_e eng_kind;
	logic [18:0] addr, arr_addr, eng_addr, a;
	logic [31:0] din, dout, arr_rdata, eng_data, d, q, q2;
	logic [31:0] seed = 32'h000122D4;
	int error_cnt = 0, num_checks = 0, starts = 0, exp_st = 0, n;
	function automatic logic [31:0] arr(input logic [18:0] x);
		return {x[12:0], x};
	endfunction
	assign arr_rdata = arr(arr_addr);
	fsb_sequencer uut (.mclk, .arst_n, .pins, .addr, .din, .sync_mode(1'h0),
		.secure_en, .query_information_mode, .password_op(1'h0),
		.wp_guarded, .sector_lock_hit, .per_sector_lock_bit,
		.arr_rdata, .arr_addr, .dout, .ready_busy_n_o, .ready_busy_n_oe,
		.eng_start, .eng_run, .eng_kind, .eng_addr, .eng_data, .eng_done,
		.eng_limit, .timing_limit_flag, .bypass_active);
	fsb_host host (.mclk, .dout, .pins, .addr, .din);
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk) if (eng_start === 1'h1) starts <= starts + 1;
	function automatic logic [31:0] nx();
		seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task unl;
		host.wr(19'h555, 32'hAA);
		host.wr(19'h2AA, 32'h55);
	endtask
	task pulse(input logic lim);
		@(posedge mclk);
		eng_done <= !lim;
		eng_limit <= lim;
		@(posedge mclk);
		eng_done <= 1'h0;
		eng_limit <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (8) @(posedge mclk);
		d = nx();
		a = {1'h1, d[17:0]};
		unl;
		host.wr(19'h555, 32'hA0);
		host.wr(a, d);
		exp_st++;
		chk(starts, exp_st);
		chk({eng_addr, eng_data[12:0]}, {a, d[12:0]});
		chk({ready_busy_n_oe, ready_busy_n_o}, 2'h2);
		host.rd(a, q);
		host.rd(a, q2);
		chk({q[31:8], q[7], q[6] ^ q2[6]}, {24'h0, ~d[7], 1'h1});
		host.rd(a ^ 19'h40000, q);
		chk(q, arr(a ^ 19'h40000));
		query_information_mode <= 1'h1;
		host.rd(a ^ 19'h40000, q);
		query_information_mode <= 1'h0;
		chk({q[31:8], q[7]}, {24'h0, ~d[7]});
		host.wr(a, 32'hB0);
		chk(eng_run, 1'h0);
		host.rd(a ^ 19'h04000, q);
		chk(q, arr(a ^ 19'h04000));
		host.wr(a, 32'h30);
		host.wr(a, 32'h30);
		chk(eng_run, 1'h1);
		pulse(1'h0);
		host.rd(a, q);
		chk({ready_busy_n_oe, q}, {1'h0, arr(a)});
		$display("test suspend done");
		unl;
		host.wr(19'h555, 32'hA0);
		host.wr(a, d);
		exp_st++;
		pulse(1'h1);
		host.rd(a, q);
		chk({timing_limit_flag, q[5]}, 2'h3);
		host.wr(a, 32'hF0);
		chk(timing_limit_flag, 1'h0);
		$display("test limit done");
		unl;
		host.wr(19'h555, 32'h20);
		chk(bypass_active, 1'h1);
		d = nx();
		host.wr(a, 32'hA0);
		host.wr(a, d);
		exp_st++;
		chk(starts, exp_st);
		host.wr(a, 32'hB0);
		chk(eng_run, 1'h1);
		pulse(1'h0);
		host.wr(a, 32'h80);
		host.wr(a, 32'h10);
		exp_st++;
		chk(eng_kind, FSB_K_CHIP);
		pulse(1'h0);
		host.wr(a, 32'h90);
		host.wr(a, 32'h00);
		chk({bypass_active, starts[7:0]}, {1'h0, exp_st[7:0]});
		$display("test bypass done");
		secure_en <= 1'h1;
		unl;
		host.wr(19'h555, 32'h20);
		host.acc(1'h1);
		chk(bypass_active, 1'h0);
		secure_en <= 1'h0;
		host.acc(1'h1);
		chk(bypass_active, 1'h1);
		sector_lock_hit <= 1'h1;
		d = nx();
		host.wr(a, 32'hA0);
		host.wr(a, d);
		exp_st++;
		pulse(1'h0);
		chk(starts, exp_st);
		wp_guarded <= 1'h1;
		host.wr(a, 32'hA0);
		host.wr(a, d);
		wp_guarded <= 1'h0;
		chk({ready_busy_n_oe, starts[7:0]}, {1'h1, exp_st[7:0]});
		for (n = 0; n < 80 && ready_busy_n_oe !== 1'h0; n++) @(posedge mclk);
		chk(n > 25 && n < 45, 1'h1);
		per_sector_lock_bit <= 1'h1;
		host.wr(a, 32'hA0);
		host.wr(a, d);
		chk({ready_busy_n_oe, starts[7:0]}, {1'h1, exp_st[7:0]});
		for (n = 0; n < 80 && ready_busy_n_oe !== 1'h0; n++) @(posedge mclk);
		chk(n < 45, 1'h1);
		sector_lock_hit <= 1'h0;
		per_sector_lock_bit <= 1'h0;
		host.acc(1'h0);
		chk(bypass_active, 1'h0);
		$display("test accelerate done");
		end_sim;
	end
endmodule
